// File: hdl/qcl_filter.sv
// module: pin synchroniser followed by a stable-count glitch filter
`timescale 1ns/1ns
module qcl_filter #(
	parameter int unsigned FILT = 2
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output logic      level_q
);
	import qcl_pkg::*;

	logic                  sync1_q;
	logic                  sync2_q;
	logic [QCL_FILT_W-1:0] stab_q;
	logic [QCL_FILT_W-1:0] stab_d;
	logic                  differs;
	logic                  settled;

	// filter compares only the second stage; first is metastability guard
	assign differs = sync2_q != level_q;
	assign settled = differs && (stab_q >= QCL_FILT_W'(FILT - 1));
	assign stab_d  = differs ? stab_q + QCL_FILT_W'(1) : '0;

	// two-stage synchroniser and filtered level
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			stab_q  <= '0;
			level_q <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			stab_q  <= settled ? '0 : stab_d;
			if (settled)
				level_q <= sync2_q;
		end
	end

endmodule : qcl_filter

// File: hdl/qcl_pkg.sv
// package: constants and types for the quadrature counter and latch block
package qcl_pkg;

	localparam int unsigned QCL_CLK_HZ       = 50_000_000;
	localparam int unsigned QCL_CNT_W        = 24;
	localparam int unsigned QCL_NUM_CH       = 5;
	localparam int unsigned QCL_LINE_RATE_HZ = 250_000;
	localparam int unsigned QCL_CNT_PER_LINE = 4;
	localparam int unsigned QCL_COUNT_RATE_HZ =
		QCL_LINE_RATE_HZ * QCL_CNT_PER_LINE;
	// shortest time between two counted edges, in nanoseconds
	localparam int unsigned QCL_EDGE_GAP_NS  = 1_000_000_000 / QCL_COUNT_RATE_HZ;
	localparam int unsigned QCL_CLK_NS       = 1_000_000_000 / QCL_CLK_HZ;
	// clocks per minimum edge gap, rounded down (longest usable time)
	localparam int unsigned QCL_EDGE_GAP_CYC = QCL_EDGE_GAP_NS / QCL_CLK_NS;
	// encoder inputs: a short glitch filter, well inside the edge gap
	localparam int unsigned QCL_ENC_FILT     = 3;
	// fast input: light filter, detected sooner than general inputs
	localparam int unsigned QCL_FAST_FILT    = 2;
	localparam int unsigned QCL_FILT_W       = 3;

	// latch trigger source selection
	typedef enum logic [1:0] {
		QCL_TRIG_INDEX     = 2'h0,
		QCL_TRIG_FAST      = 2'h1,
		QCL_TRIG_FAST_IDX  = 2'h2,
		QCL_TRIG_OFF       = 2'h3
	} qcl_trig_t;

	// per channel capture state, one-hot
	typedef enum logic [2:0] {
		QCL_ST_IDLE  = 3'b001,
		QCL_ST_ARMED = 3'b010,
		QCL_ST_WAIT  = 3'b100
	} qcl_state_t;

endpackage : qcl_pkg

// File: hdl/qcl_quad_latch.sv
// module: five-channel quadrature position counter with event capture
//
// Behaviour
// - 24-bit up/down count, one step on each A or B edge.
// - direction from phase: A leading B counts up, lagging counts down.
// - keeps up with 250k lines/s, four counts per line, no lost edges.
// - each channel has a 24-bit capture register snapshotting its count.
// - capture may be triggered by the encoder index pulse.
// - capture may be triggered by a chosen edge of the fast input.
// - armed by the fast-input edge, capture on the next index pulse.
// - five capture registers, each with its own fast input.
// - fast-input capture is done in hardware, no software delay.
// - fast input filtered lighter than general inputs, so faster.
`timescale 1ns/1ns
module qcl_quad_latch
	import qcl_pkg::*;
#(
	parameter int unsigned NUM_CH    = QCL_NUM_CH,
	parameter int unsigned CNT_W     = QCL_CNT_W,
	parameter int unsigned ENC_FILT  = QCL_ENC_FILT,
	parameter int unsigned FAST_FILT = QCL_FAST_FILT
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic [NUM_CH-1:0]     enc_a,
	input  wire logic [NUM_CH-1:0]     enc_b,
	input  wire logic [NUM_CH-1:0]     enc_index,
	input  wire logic [NUM_CH-1:0]     fast_in,
	input  wire logic [2*NUM_CH-1:0]   trig_sel,
	input  wire logic [NUM_CH-1:0]     fast_neg_edge,
	input  wire logic [NUM_CH-1:0]     arm,
	input  wire logic [NUM_CH-1:0]     latch_read,
	output logic [NUM_CH*CNT_W-1:0]    position_count_unit,
	output logic [NUM_CH*CNT_W-1:0]    latch_value,
	output logic [NUM_CH-1:0]          latch_new,
	output logic [NUM_CH-1:0]          latch_armed
);

	////////////////////////////////////////////////////////////////////////
	// direction decode shared by every channel

	// returns +1 step, -1 step or none from old and new phase pairs
	function automatic logic [1:0] qcl_step(input logic [1:0] old_ab,
		input logic [1:0] new_ab);
		logic [3:0] key;
		key = {old_ab, new_ab};
		// bit1: move, bit0: up; double steps are impossible below rate
		unique case (key)
			4'b0010, 4'b1011, 4'b1101, 4'b0100: qcl_step = 2'b11;
			4'b0001, 4'b0111, 4'b1110, 4'b1000: qcl_step = 2'b10;
			default:                            qcl_step = 2'b00;
		endcase
	endfunction : qcl_step

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch

			////////////////////////////////////////////////////////////
			// input conditioning

			logic a_f;
			logic b_f;
			logic idx_f;
			logic fast_f;

			// true phases used
			// the complementary lines are resolved by the line receiver
			qcl_filter #(.FILT(ENC_FILT)) u_fa (
				.core_clk (core_clk),
				.rst      (rst),
				.pin_in   (enc_a[ch]),
				.level_q  (a_f)
			);
			qcl_filter #(.FILT(ENC_FILT)) u_fb (
				.core_clk (core_clk),
				.rst      (rst),
				.pin_in   (enc_b[ch]),
				.level_q  (b_f)
			);
			qcl_filter #(.FILT(ENC_FILT)) u_fi (
				.core_clk (core_clk),
				.rst      (rst),
				.pin_in   (enc_index[ch]),
				.level_q  (idx_f)
			);
			// lighter fast filter
			// trades noise immunity for a shorter detection delay
			qcl_filter #(.FILT(FAST_FILT)) u_ff (
				.core_clk (core_clk),
				.rst      (rst),
				.pin_in   (fast_in[ch]),
				.level_q  (fast_f)
			);

			////////////////////////////////////////////////////////////
			// position counter

			logic [1:0]       ab_q;
			logic             idx_q;
			logic             fast_q;
			logic [CNT_W-1:0] cnt_q;
			logic [CNT_W-1:0] cnt_d;
			logic [1:0]       step;

			assign step = qcl_step(ab_q, {a_f, b_f});
			assign cnt_d = !step[1] ? cnt_q :
				step[0] ? cnt_q + CNT_W'(1) : cnt_q - CNT_W'(1);

			// single-cycle update
			// one edge per 20 ns clock is far beyond the 1 us edge gap
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					ab_q   <= 2'b00;
					idx_q  <= 1'b0;
					fast_q <= 1'b0;
					cnt_q  <= '0;
				end else begin
					ab_q   <= {a_f, b_f};
					idx_q  <= idx_f;
					fast_q <= fast_f;
					cnt_q  <= cnt_d;
				end
			end

			////////////////////////////////////////////////////////////
			// capture control

			qcl_trig_t  sel;
			qcl_state_t st_q;
			qcl_state_t st_d;
			logic       idx_rise;
			logic       fast_edge;
			logic       take;
			logic [CNT_W-1:0] lat_q;
			logic       new_q;

			assign sel      = qcl_trig_t'(trig_sel[2*ch +: 2]);
			assign idx_rise = idx_f && !idx_q;
			assign fast_edge = fast_neg_edge[ch] ? (!fast_f && fast_q)
				: (fast_f && !fast_q);

			// fast capture in hardware, same cycle as detection
			assign take =
				(st_q == QCL_ST_ARMED &&
					((sel == QCL_TRIG_INDEX && idx_rise) ||
					 (sel == QCL_TRIG_FAST && fast_edge))) ||
				(st_q == QCL_ST_WAIT && idx_rise);

			always_comb begin
				st_d = st_q;
				unique case (st_q)
					QCL_ST_IDLE:
						if (arm[ch] && !new_q && sel != QCL_TRIG_OFF)
							st_d = QCL_ST_ARMED;
					QCL_ST_ARMED:
						if (take)
							st_d = QCL_ST_IDLE;
						else if (sel == QCL_TRIG_FAST_IDX && fast_edge)
							st_d = QCL_ST_WAIT;
						else if (sel == QCL_TRIG_OFF)
							st_d = QCL_ST_IDLE;
					QCL_ST_WAIT:
						if (take || sel == QCL_TRIG_OFF)
							st_d = QCL_ST_IDLE;
					default:
						st_d = QCL_ST_IDLE;
				endcase
			end

			// hold and flag new
			// a capture in the read cycle wins so no event is lost
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					st_q  <= QCL_ST_IDLE;
					lat_q <= '0;
					new_q <= 1'b0;
				end else begin
					st_q <= st_d;
					if (take)
						lat_q <= cnt_d;
					new_q <= take || (new_q && !latch_read[ch]);
				end
			end

			////////////////////////////////////////////////////////////
			// registered outputs

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					position_count_unit[ch*CNT_W +: CNT_W] <= '0;
					latch_value[ch*CNT_W +: CNT_W]         <= '0;
					latch_new[ch]                          <= 1'b0;
					latch_armed[ch]                        <= 1'b0;
				end else begin
					position_count_unit[ch*CNT_W +: CNT_W] <= cnt_q;
					latch_value[ch*CNT_W +: CNT_W]         <= lat_q;
					latch_new[ch]                          <= new_q;
					latch_armed[ch] <= st_q != QCL_ST_IDLE;
				end
			end
		end
	endgenerate

endmodule : qcl_quad_latch

// File: test/qcl_enc_model.sv
// partner model: five-channel differential quadrature encoder
`timescale 1ns/1ns
module qcl_enc_model #(
	parameter int unsigned GAP = 50
) (
	input  wire logic   core_clk,
	output logic [4:0]  enc_a,
	output logic [4:0]  enc_a_n,
	output logic [4:0]  enc_b,
	output logic [4:0]  enc_b_n,
	output logic [4:0]  enc_index
);
	int ph [5] = '{default: 0};
	assign enc_a_n = ~enc_a;
	assign enc_b_n = ~enc_b;
	initial begin
		enc_a = '0;
		enc_b = '0;
		enc_index = '0;
	end
	// a leads b going up, edges at max rate
	task automatic step(input int ch, input bit up);
		@(posedge core_clk);
		#2;
		ph[ch] = up ? (ph[ch] + 1) % 4 : (ph[ch] + 3) % 4;
		enc_a[ch] = (ph[ch] == 1) || (ph[ch] == 2);
		enc_b[ch] = ph[ch] >= 2;
		repeat (GAP - 1) @(posedge core_clk);
	endtask : step
	// index wider than the filter so it is never dropped
	task automatic pulse_index(input int ch);
		@(posedge core_clk);
		#2 enc_index[ch] = 1'b1;
		repeat (6) @(posedge core_clk);
		#2 enc_index[ch] = 1'b0;
	endtask : pulse_index
endmodule : qcl_enc_model

// File: test/qcl_properties.sv
// checker: capture handshake and count steps on channel 0
`timescale 1ns/1ns
module qcl_chk
	import qcl_pkg::*;
#(
	parameter int unsigned NUM_CH = QCL_NUM_CH,
	parameter int unsigned CNT_W  = QCL_CNT_W
) (
	input wire logic                    core_clk,
	input wire logic                    rst,
	input wire logic [2*NUM_CH-1:0]     trig_sel,
	input wire logic [NUM_CH-1:0]       arm,
	input wire logic [NUM_CH-1:0]       latch_read,
	input wire logic [NUM_CH*CNT_W-1:0] position_count_unit,
	input wire logic [NUM_CH*CNT_W-1:0] latch_value,
	input wire logic [NUM_CH-1:0]       latch_new,
	input wire logic [NUM_CH-1:0]       latch_armed
);
	logic [CNT_W-1:0] c0;
	assign c0 = position_count_unit[CNT_W-1:0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	arm_taken_a: assert property ($rose(latch_armed[0]) |->
		$past(arm[0], 2)) else $error("armed without request");
	armed_not_new_a: assert property (latch_armed[0] |->
		!latch_new[0]) else $error("armed while new");
	capture_disarm_a: assert property ($rose(latch_new[0]) |->
		$fell(latch_armed[0])) else $error("armed kept at capture");
	capture_armed_a: assert property ($rose(latch_new[0]) |->
		$past(latch_armed[0])) else $error("capture when idle");
	read_clears_a: assert property (latch_read[0] && latch_new[0]
		|-> ##2 !latch_new[0]) else $error("new not cleared");
	value_hold_a: assert property (latch_new[0] && $past(latch_new[0])
		|-> $stable(latch_value[CNT_W-1:0])) else $error("value moved");
	count_step_a: assert property ($changed(c0) |->
		CNT_W'(c0 - $past(c0)) == 1 || CNT_W'($past(c0) - c0) == 1)
		else $error("count jump");
	off_disarm_a: assert property (trig_sel[1:0] == 2'h3
		|-> ##[1:3] !latch_armed[0]) else $error("armed while off");
endmodule : qcl_chk

// File: test/tb_top.sv
// testbench: counting and every capture mode over the encoder model
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	import qcl_pkg::*;
	logic         core_clk, rst;
	wire  [4:0]   enc_a, enc_b, enc_index;
	logic [4:0]   fast_in, fast_neg_edge, arm, latch_read;
	logic [9:0]   trig_sel;
	logic [119:0] position_count_unit, latch_value;
	logic [4:0]   latch_new, latch_armed;
	logic [23:0]  ex [5] = '{default: 0};
	int           errors = 0, n_checks = 0;
	initial begin
		core_clk = 0;
		forever #10 core_clk = ~core_clk;
	end
	qcl_enc_model m (.core_clk, .enc_a, .enc_a_n(), .enc_b, .enc_b_n(),
		.enc_index);
	qcl_quad_latch dut (.core_clk, .rst, .enc_a, .enc_b, .enc_index,
		.fast_in, .trig_sel, .fast_neg_edge, .arm, .latch_read,
		.position_count_unit, .latch_value, .latch_new, .latch_armed);
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic pulse(ref logic [4:0] s, input int ch);
		#2 s[ch] = 1'b1;
		@(posedge core_clk);
		#2 s[ch] = 1'b0;
	endtask : pulse
	// up on all channels, then down through zero on channel 0
	task automatic t_count;
		for (int ch = 0; ch < 5; ch++) begin
			repeat (4) m.step(ch, 1);
			ex[ch] = 24'h0000_04;
			repeat (10) @(posedge core_clk);
			`CHK("count", ex[ch], position_count_unit[24*ch+:24])
		end
		repeat (6) m.step(0, 0);
		ex[0] = 24'hFF_FFFE;
		repeat (10) @(posedge core_clk);
		`CHK("count down", ex[0], position_count_unit[23:0])
	endtask : t_count
	// arm, trigger in the given mode, refuse rearm, read
	task automatic t_latch(input int ch, input logic [1:0] md, input bit ng);
		#2 trig_sel[2*ch+:2] = md;
		fast_neg_edge[ch] = ng;
		fast_in[ch] = ng;
		repeat (8) @(posedge core_clk);
		pulse(arm, ch);
		repeat (3) @(posedge core_clk);
		`CHK("armed", 1'b1, latch_armed[ch])
		if (md != 0) #2 fast_in[ch] = !ng;
		repeat (10) @(posedge core_clk);
		if (md == 2) `CHK("wait idx", 1'b0, latch_new[ch])
		if (md != 1) m.pulse_index(ch);
		repeat (10) @(posedge core_clk);
		`CHK("new", 1'b1, latch_new[ch])
		`CHK("value", ex[ch], latch_value[24*ch+:24])
		pulse(arm, ch);
		m.step(ch, 1);
		repeat (10) @(posedge core_clk);
		`CHK("held", ex[ch], latch_value[24*ch+:24])
		`CHK("no rearm", 1'b0, latch_armed[ch])
		ex[ch]++;
		#2 fast_in[ch] = ng;
		pulse(latch_read, ch);
		repeat (3) @(posedge core_clk);
		`CHK("read", 1'b0, latch_new[ch])
	endtask : t_latch
	// selecting off while armed drops the arm and blocks a later index capture
	task automatic t_off;
		#2 trig_sel[3:2] = 2'h0;
		pulse(arm, 1);
		repeat (3) @(posedge core_clk);
		`CHK("off armed", 1'b1, latch_armed[1])
		#2 trig_sel[3:2] = 2'h3;
		repeat (4) @(posedge core_clk);
		`CHK("off disarm", 1'b0, latch_armed[1])
		m.pulse_index(1);
		repeat (10) @(posedge core_clk);
		`CHK("off no take", 1'b0, latch_new[1])
	endtask : t_off
	initial begin
		rst = 1;
		{fast_in, fast_neg_edge, arm, latch_read} = '0;
		trig_sel = '1;
		repeat (3) @(posedge core_clk);
		#2 rst = 0;
		t_count();
		t_latch(0, 2'h0, 0);
		t_latch(0, 2'h1, 0);
		t_latch(0, 2'h1, 1);
		t_latch(0, 2'h2, 0);
		t_latch(4, 2'h1, 1);
		t_off();
		end_of_test();
	end
	// watchdog well beyond the nearly two thousand cycles needed
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		end_of_test();
	end
endmodule : tb_top
bind qcl_quad_latch qcl_chk #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) chk (
	.core_clk, .rst, .trig_sel, .arm, .latch_read, .position_count_unit,
	.latch_value, .latch_new, .latch_armed);
